//--- rtl/ars_pkg.sv
// constants, register map and codes of the autorange selector
package ars_pkg;

    // ****************************************************************
    // register map (byte offsets on wishbone)
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_RESULT   = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h14;

    // ctrl fields: mode one-hot [3:0], group one-hot [6:4], override [9:8]
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_GROUP_LSB = 4;
    localparam int CTRL_OVR_LSB   = 8;
    localparam logic [3:0] MODE_DC    = 4'h1;
    localparam logic [3:0] MODE_RES   = 4'h2;
    localparam logic [3:0] MODE_AC    = 4'h4;
    localparam logic [3:0] MODE_HF    = 4'h8;
    localparam logic [2:0] GROUP_RST  = 3'h1;

    // override codes
    localparam logic [1:0] OVR_AUTO = 2'h0;
    localparam logic [1:0] OVR_10   = 2'h1;
    localparam logic [1:0] OVR_100  = 2'h2;
    localparam logic [1:0] OVR_1000 = 2'h3;

    // range index: 0 is 1:1 (most sensitive), 2 is 1:100 (least sensitive)
    localparam logic [1:0] RANGE_X1   = 2'h0;
    localparam logic [1:0] RANGE_X10  = 2'h1;
    localparam logic [1:0] RANGE_X100 = 2'h2;

    // sign display codes
    localparam logic [1:0] SIGN_BLANK = 2'h0;
    localparam logic [1:0] SIGN_PLUS  = 2'h1;
    localparam logic [1:0] SIGN_MINUS = 2'h2;
    localparam logic [1:0] SIGN_ALT   = 2'h3;

    // interrupt bits
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_STEP  = 1;
    localparam int IRQ_LIMIT = 2;

    // thresholds and timing
    localparam int          CNT_W      = 12;
    localparam logic [11:0] CNT_LOW    = 12'h063;  // 99
    localparam logic [11:0] CNT_HIGH   = 12'h578;  // 1400
    localparam logic [11:0] CNT_SAT    = 12'hFFF;
    localparam int          UP_CLKS    = 1000;
    localparam int          CLK_HZ     = 125_000_000;
    localparam int          SETTLE_MS  = 100;
    localparam int          SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;
    localparam int          CONV_DIV   = 4;

    typedef enum logic [3:0] {
        ST_SETTLE = 4'h1,
        ST_UP     = 4'h2,
        ST_DOWN   = 4'h4,
        ST_EVAL   = 4'h8
    } ars_state_e;

endpackage

//--- rtl/ars_autorange.sv
// autorange selector: conversion sequencing, range stepping, display control
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ns
module ars_autorange #(
    parameter int SETTLE_CYCLES = ars_pkg::SETTLE_CYC,
    parameter int CONV_DIVIDE   = ars_pkg::CONV_DIV
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [3:0]               wb_sel_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     zero_cross_i,
    input  wire logic                     polarity_neg_i,
    input  wire logic                     input_open_i,
    output logic                          integ_up_o,
    output logic                          integ_down_o,
    output logic      [1:0]               range_o,
    output logic      [2:0]               group_o,
    output logic      [3:0]               mode_o,
    output logic      [1:0]               dp_pos_o,
    output logic      [1:0]               sign_o,
    output logic                          range_limit_lamp_o,
    output logic      [ars_pkg::CNT_W-1:0] display_o,
    output logic                          irq_o
);
    import ars_pkg::*;

    // ****************************************************************
    // pin synchronisers: three stages, accept when stages 2 and 3 agree
    // ****************************************************************
    logic [2:0] s1_reg, s2_reg, s3_reg, pin_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_reg  <= 3'h0;
            s2_reg  <= 3'h0;
            s3_reg  <= 3'h0;
            pin_reg <= 3'h0;
        end
        else
        begin
            s1_reg <= {input_open_i, polarity_neg_i, zero_cross_i};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < 3; i++)
                if (s2_reg[i] == s3_reg[i])
                    pin_reg[i] <= s3_reg[i];
        end
    end
    logic zc, neg, open_now, open_prev_reg;
    assign zc       = pin_reg[0];
    assign neg      = pin_reg[1];
    assign open_now = pin_reg[2];

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    logic       req, wr;
    logic [3:0] mode_reg;
    logic [2:0] group_reg;
    logic [1:0] ovr_reg;
    logic [2:0] irq_stat_reg, irq_en_reg, irq_evt;
    logic       restart_reg;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_reg    <= MODE_DC;
            group_reg   <= GROUP_RST;
            ovr_reg     <= OVR_AUTO;
            irq_en_reg  <= 3'h0;
            restart_reg <= 1'b0;
        end
        else
        begin
            restart_reg <= 1'b0;
            if (wr && wb_adr_i == OFS_CTRL)
            begin
                // a mode field that selects more or fewer than one mode is ignored; group and override still apply
                if ($onehot(wb_dat_i[CTRL_MODE_LSB +: 4]))
                    mode_reg <= wb_dat_i[CTRL_MODE_LSB +: 4];
                // a new coarse group restarts autoranging
                if ($onehot(wb_dat_i[CTRL_GROUP_LSB +: 3]))
                begin
                    group_reg   <= wb_dat_i[CTRL_GROUP_LSB +: 3];
                    restart_reg <= wb_dat_i[CTRL_GROUP_LSB +: 3] != group_reg;
                end
            end
            if (req && wb_we_i && wb_sel_i[1] && wb_adr_i == OFS_CTRL)
                ovr_reg <= wb_dat_i[CTRL_OVR_LSB +: 2];
            if (wr && wb_adr_i == OFS_IRQ_EN)
                irq_en_reg <= wb_dat_i[2:0];
            // interrupted input also restarts
            if (open_now && !open_prev_reg)
                restart_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            open_prev_reg <= 1'b0;
        else
            open_prev_reg <= open_now;
    end

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************
    ars_state_e         state_reg;
    logic [1:0]         range_reg;
    logic [CNT_W-1:0]   count_reg, result_reg;
    logic [31:0]        settle_reg;
    logic [15:0]        div_reg;
    logic               tick, lamp_reg, neg_reg;
    logic               auto_mode, want_up, want_down;

    assign tick      = div_reg == 16'(CONV_DIVIDE - 1);
    assign auto_mode = ovr_reg == OVR_AUTO;
    // thresholds use only the latched result
    assign want_up   = result_reg <= CNT_LOW && range_reg != RANGE_X1;
    assign want_down = result_reg >= CNT_HIGH && range_reg != RANGE_X100;

    function automatic logic [1:0] forced_range(input logic [1:0] ovr);
        unique case (ovr)
            OVR_10:   forced_range = RANGE_X1;
            OVR_100:  forced_range = RANGE_X10;
            default:  forced_range = RANGE_X100;
        endcase
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (rst_i || state_reg != ST_UP && state_reg != ST_DOWN || tick)
            div_reg <= 16'h0;
        else
            div_reg <= div_reg + 16'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg  <= ST_SETTLE;
            range_reg  <= RANGE_X1;
            count_reg  <= '0;
            result_reg <= '0;
            settle_reg <= 32'h0;
            neg_reg    <= 1'b0;
            lamp_reg   <= 1'b0;
        end
        else if (restart_reg && auto_mode)
        begin
            range_reg  <= RANGE_X1;
            state_reg  <= ST_SETTLE;
            settle_reg <= 32'h0;
        end
        else
        begin
            if (!auto_mode)
                range_reg <= forced_range(ovr_reg);
            unique case (state_reg)
                ST_SETTLE:
                begin
                    settle_reg <= settle_reg + 32'h1;
                    if (settle_reg >= 32'(SETTLE_CYCLES - 1))
                    begin
                        state_reg <= ST_UP;
                        count_reg <= '0;
                    end
                end
                ST_UP:
                    if (tick)
                    begin
                        // fixed upward integration of 1000 periods
                        if (count_reg == CNT_W'(UP_CLKS - 1))
                        begin
                            neg_reg   <= neg;
                            count_reg <= '0;
                            state_reg <= ST_DOWN;
                        end
                        else
                            count_reg <= count_reg + 1'b1;
                    end
                ST_DOWN:
                    if (zc || count_reg == CNT_SAT)
                    begin
                        result_reg <= count_reg;
                        state_reg  <= ST_EVAL;
                    end
                    else if (tick)
                        count_reg <= count_reg + 1'b1;
                ST_EVAL:
                begin
                    // lamp on the least sensitive range at 1400 or more
                    lamp_reg   <= range_reg == RANGE_X100 && result_reg >= CNT_HIGH;
                    count_reg  <= '0;
                    settle_reg <= 32'h0;
                    if (auto_mode && (want_up || want_down))
                    begin
                        // one step, then settle before the next conversion
                        range_reg <= want_up ? range_reg - 2'h1 : range_reg + 2'h1;
                        state_reg <= ST_SETTLE;
                    end
                    else
                        state_reg <= ST_UP;
                end
            endcase
        end
    end

    // ****************************************************************
    // display and outputs
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sign_o    <= SIGN_BLANK;
            display_o <= '0;
        end
        else if (state_reg == ST_EVAL)
        begin
            display_o <= result_reg;
            unique case (mode_reg)
                MODE_DC:  sign_o <= neg_reg ? SIGN_MINUS : SIGN_PLUS;
                MODE_RES: sign_o <= SIGN_BLANK;
                default:  sign_o <= SIGN_ALT;
            endcase
        end
    end

    assign integ_up_o         = state_reg == ST_UP;
    assign integ_down_o       = state_reg == ST_DOWN;
    assign range_o            = range_reg;
    assign dp_pos_o           = range_reg;
    assign group_o            = group_reg;
    assign mode_o             = mode_reg;
    assign range_limit_lamp_o = lamp_reg;

    // ****************************************************************
    // interrupts: set wins over clear
    // ****************************************************************
    assign irq_evt = {state_reg == ST_EVAL && range_reg == RANGE_X100 && result_reg >= CNT_HIGH,
                      state_reg == ST_EVAL && auto_mode && (want_up || want_down),
                      state_reg == ST_EVAL};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_stat_reg <= 3'h0;
        else if (wr && wb_adr_i == OFS_IRQ_CLR)
            irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[2:0]) | irq_evt;
        else
            irq_stat_reg <= irq_stat_reg | irq_evt;
    end
    assign irq_o = |(irq_stat_reg & irq_en_reg);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0;
            if (req && !wb_we_i)
                unique case (wb_adr_i)
                    OFS_CTRL:     wb_dat_o <= {22'h0, ovr_reg, 1'b0, group_reg, mode_reg};
                    OFS_STATUS:   wb_dat_o <= {24'h0, state_reg, sign_o, lamp_reg, 1'b0}
                                              | {30'h0, range_reg} << 8;
                    OFS_RESULT:   wb_dat_o <= {19'h0, neg_reg, result_reg};
                    OFS_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_reg};
                    OFS_IRQ_EN:   wb_dat_o <= {29'h0, irq_en_reg};
                    default:      wb_dat_o <= 32'h0;
                endcase
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    step_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_EVAL && auto_mode && !restart_reg && result_reg <= CNT_LOW
        && range_reg != RANGE_X1 |=> range_reg == $past(range_reg) - 2'h1)
        else $error("range did not step more sensitive");
    step_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_EVAL && auto_mode && !restart_reg && result_reg >= CNT_HIGH
        && range_reg != RANGE_X100 |=> range_reg == $past(range_reg) + 2'h1)
        else $error("range did not step less sensitive");
    range_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_EVAL && !restart_reg && result_reg > CNT_LOW && result_reg < CNT_HIGH
        |=> $stable(range_reg) && state_reg == ST_UP)
        else $error("range moved inside the window");
    limit_lamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_EVAL && !restart_reg |=> range_limit_lamp_o ==
        ($past(range_reg) == RANGE_X100 && $past(result_reg) >= CNT_HIGH))
        else $error("limit lamp wrong");
    low_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_EVAL && auto_mode && !restart_reg && range_reg == RANGE_X1
        && result_reg < CNT_LOW |=> range_reg == RANGE_X1 && state_reg == ST_UP)
        else $error("most sensitive range not held");
    override_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !auto_mode && $stable(ovr_reg) |=> range_reg == forced_range($past(ovr_reg)))
        else $error("override range not applied");
    mode_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot(mode_o))
        else $error("modes not exclusive");
    sign_res_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_EVAL && mode_reg == MODE_RES |=> sign_o == SIGN_BLANK)
        else $error("sign not blank for resistance");
    restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
        restart_reg && auto_mode |=> range_reg == RANGE_X1 && state_reg == ST_SETTLE)
        else $error("restart did not return to most sensitive range");
    settle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_EVAL && $changed(range_reg) == 1'b0 && auto_mode && !restart_reg
        && (want_up || want_down) |=> state_reg == ST_SETTLE && settle_reg == 32'h0)
        else $error("no settle delay after a step");
    up_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_UP && $past(state_reg) == ST_UP && !restart_reg
        |-> count_reg < CNT_W'(UP_CLKS))
        else $error("upward phase too long");
    one_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_mode && $past(auto_mode) && $changed(range_reg)
        |-> $past(state_reg) == ST_EVAL || $past(restart_reg))
        else $error("range changed outside evaluation");

endmodule

//--- tb/ars_integrator_model.sv
// integrator and zero-crossing comparator standing in for the analogue side
`timescale 1ns/1ns
module ars_integrator_model (
    input  wire logic        clk_i,
    input  wire logic        integ_down_i,
    input  wire logic [1:0]  range_i,
    input  wire logic [31:0] level_i,
    output logic             zero_cross_o
);
    int unsigned elapsed;
    int unsigned target;
    // discharge time shrinks by one decade for each less sensitive range
    always_comb target = level_i / (range_i == 2'h0 ? 1 : (range_i == 2'h1 ? 10 : 100));
    // comparator rests low outside the discharge phase
    always_ff @(posedge clk_i)
    begin
        if (!integ_down_i)
        begin
            elapsed      <= 0;
            zero_cross_o <= 1'b0;
        end
        else
        begin
            elapsed      <= elapsed + 1;
            zero_cross_o <= (elapsed >= target);
        end
    end
endmodule

//--- tb/autorange_selector_tb_top.sv
// self-checking bench of the autorange selector
`timescale 1ns/1ns
module autorange_selector_tb_top;
    import ars_pkg::*;
    typedef struct {
        int unsigned level;
        logic [3:0]  mode;
        logic        neg;
        logic [1:0]  rng;
        logic        lamp;
        logic [1:0]  sign;
    } ars_row_s;
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0, wb_dat_o, level = 32'h0;
    logic        wb_ack_o, zero_cross, pol_neg = 1'b0, input_open = 1'b0;
    logic        integ_up_o, integ_down_o, range_limit_lamp_o, irq_o;
    logic [1:0]  range_o, dp_pos_o, sign_o;
    logic [2:0]  group_o;
    logic [3:0]  mode_o;
    logic [11:0] display_o;
    int          fails = 0, tests_run = 0, cycles = 0;
    ars_row_s    rows [5] = '{'{500, MODE_DC, 1'b0, RANGE_X1, 1'b0, SIGN_PLUS},
        '{20000, MODE_DC, 1'b1, RANGE_X100, 1'b0, SIGN_MINUS},
        '{200000, MODE_RES, 1'b0, RANGE_X100, 1'b1, SIGN_BLANK},
        '{5000, MODE_AC, 1'b0, RANGE_X10, 1'b0, SIGN_ALT},
        '{30, MODE_HF, 1'b0, RANGE_X1, 1'b0, SIGN_ALT}};
    always #4 clk_i = ~clk_i;
    ars_autorange #(.SETTLE_CYCLES(20), .CONV_DIVIDE(1)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .zero_cross_i(zero_cross), .polarity_neg_i(pol_neg),
        .input_open_i(input_open), .integ_up_o(integ_up_o), .integ_down_o(integ_down_o),
        .range_o(range_o), .group_o(group_o), .mode_o(mode_o), .dp_pos_o(dp_pos_o),
        .sign_o(sign_o), .range_limit_lamp_o(range_limit_lamp_o), .display_o(display_o),
        .irq_o(irq_o));
    ars_integrator_model far_side (.clk_i(clk_i), .integ_down_i(integ_down_o),
        .range_i(range_o), .level_i(level), .zero_cross_o(zero_cross));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // waits for n completed conversions and lets the evaluation land
    task automatic wait_conv(input int n);
        repeat (n) @(negedge integ_down_o);
        repeat (3) @(posedge clk_i);
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        // the whole sequence needs about 76,000 cycles
        if (cycles == 95000)
        begin
            fails++;
            summarize();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] q;
        int          n;
        logic [1:0]  ovr [3];
        logic [1:0]  forced [3];
        ovr = '{OVR_10, OVR_100, OVR_1000};
        forced = '{RANGE_X1, RANGE_X10, RANGE_X100};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("reset range", range_o, RANGE_X1);
        check("reset mode", mode_o, MODE_DC);
        check("reset group", group_o, GROUP_RST);
        check("reset sign", sign_o, SIGN_BLANK);
        check("reset outs", {range_limit_lamp_o, irq_o, integ_up_o, integ_down_o, display_o}, 32'h0);
        wb_rw(1'b0, OFS_CTRL, 32'h0, q);
        check("ctrl", q, 32'h0000_0011);
        wb_rw(1'b0, OFS_IRQ_EN, 32'h0, q);
        check("irq enable", q, 32'h0);
        wb_rw(1'b0, 8'h20, 32'h0, q);
        check("unmapped", q, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            level   <= rows[i].level;
            pol_neg <= rows[i].neg;
            wb_rw(1'b1, OFS_CTRL, {25'h0, GROUP_RST, rows[i].mode}, q);
            wait_conv(4);
            check("range", range_o, rows[i].rng);
            check("point", dp_pos_o, rows[i].rng);
            check("lamp", range_limit_lamp_o, rows[i].lamp);
            check("sign", sign_o, rows[i].sign);
            n = rows[i].level / (10 ** rows[i].rng);
            check("count", {31'h0, display_o >= n && display_o <= n + 8}, 32'h1);
        end
        wb_rw(1'b0, OFS_STATUS, 32'h0, q);
        check("status range", q[9:8], RANGE_X1);
        wb_rw(1'b0, OFS_RESULT, 32'h0, q);
        check("result", {31'h0, q[11:0] >= 12'h01E && q[11:0] <= 12'h026}, 32'h1);
        check("result sign", q[12], 1'b0);
        // every kind of event has happened since reset and none was cleared yet
        wb_rw(1'b0, OFS_IRQ_STAT, 32'h0, q);
        check("irq events", q, 32'h7);
        wb_rw(1'b1, OFS_IRQ_CLR, 32'h7, q);
        wb_rw(1'b1, OFS_IRQ_EN, 32'h1, q);
        wait_conv(1);
        check("irq raised", irq_o, 1'b1);
        wb_rw(1'b1, OFS_IRQ_CLR, 32'h1, q);
        @(posedge clk_i);
        check("irq cleared", irq_o, 1'b0);
        wb_rw(1'b1, OFS_IRQ_EN, 32'h0, q);
        wait_conv(1);
        check("irq masked", irq_o, 1'b0);
        wb_rw(1'b0, OFS_IRQ_STAT, 32'h0, q);
        check("irq status", q[IRQ_DONE], 1'b1);
        level <= 32'd20000;
        for (int k = 0; k < 3; k++)
        begin
            wb_rw(1'b1, OFS_CTRL, {22'h0, ovr[k], 1'b0, GROUP_RST, MODE_DC}, q);
            wait_conv(2);
            check("forced range", range_o, forced[k]);
        end
        wb_rw(1'b1, OFS_CTRL, {22'h0, OVR_AUTO, 1'b0, GROUP_RST, MODE_DC}, q);
        wait_conv(4);
        // the pin filter drops a one-cycle blip, so the interruption lasts three
        input_open <= 1'b1;
        repeat (3) @(posedge clk_i);
        input_open <= 1'b0;
        repeat (6) @(posedge clk_i);
        check("open restart", range_o, RANGE_X1);
        wait_conv(1);
        check("one step", range_o, RANGE_X10);
        wb_rw(1'b1, OFS_CTRL, 32'h0000_0021, q);
        repeat (3) @(posedge clk_i);
        check("group", group_o, 3'h2);
        check("group restart", range_o, RANGE_X1);
        @(negedge integ_down_o);
        n = 0;
        do begin @(posedge clk_i); n++; end while (integ_up_o !== 1'b1);
        check("settle", {31'h0, n >= 21 && n <= 24}, 32'h1);
        n = 1;
        @(posedge clk_i);
        while (integ_up_o === 1'b1) begin n++; @(posedge clk_i); end
        check("upward", n, UP_CLKS);
        wb_rw(1'b1, OFS_CTRL, 32'h0000_0023, q);
        @(posedge clk_i);
        check("mode one-hot", mode_o, MODE_DC);
        summarize();
    end
endmodule
